// ### stp_port_state_and_snoop_trap.sv
// Spanning tree port gating, snoop trapping and register slave
//
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
// Functional notes
// - Host port is the processor attachment point
// - Ports one, two: three bits select state
// - Closed port: only processor traffic, no learning, override only
// - Listening/learning: only processor traffic passes
// - Learning disable zero enables learning while closed
// - Forwarding state: normal traffic, learning active
// - IGMP frames from ports one, two with receive enabled go to host port only
// - IGMP: IPv4 ether or SNAP, version 4, proto 2
// - Static multicast hit limits to listed ports
// - MLD enable bit 13, option bit 12
// - Option adds headers 43,44,50,51,60
module stp_port_state_and_snoop_trap (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [2:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic hdr_valid_in,
  input wire logic [1:0] src_port_in,
  input wire logic [15:0] length_type_in,
  input wire logic snap_ok_in,
  input wire logic [15:0] snap_type_in,
  input wire logic [3:0] ip_ver_in,
  input wire logic [7:0] ip_proto_in,
  input wire logic [7:0] ip6_dst_top_in,
  input wire logic [7:0] hop_limit_in,
  input wire logic [7:0] next_hdr_in,
  input wire logic [7:0] hbh_next_hdr_in,
  input wire logic static_hit_in,
  input wire logic static_override_in,
  input wire logic [2:0] static_ports_in,
  input wire logic [2:0] lookup_ports_in,
  output logic dec_valid_out,
  output logic [2:0] dest_ports_out,
  output logic learn_out,
  output logic trap_out
);
  function automatic stp_pkg::stp_class_t port_class(input logic [15:0] ctrl);
    logic [2:0] b;
    b = {ctrl[stp_pkg::BIT_TX_EN], ctrl[stp_pkg::BIT_RX_EN], ctrl[stp_pkg::BIT_LEARN_DIS]};
    case (b)
      3'h1: port_class = stp_pkg::STP_CLOSED;
      3'h0: port_class = stp_pkg::STP_LEARN;
      3'h6: port_class = stp_pkg::STP_FORWARD;
      default: port_class = stp_pkg::STP_OTHER;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register slave
  stp_pkg::stp_bus_t bus_ff, nxt_bus;
  logic [15:0] glob_ff, nxt_glob;
  logic [15:0] p1_ff, nxt_p1;
  logic [15:0] p2_ff, nxt_p2;
  logic [31:0] rdata_ff, nxt_rdata;
  logic wait_ff, nxt_wait;
  logic [7:0] igmp_cnt_ff, nxt_igmp_cnt;
  logic [7:0] mld_cnt_ff, nxt_mld_cnt;
  logic req;
  logic [31:0] status;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
    input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  always_comb begin
    req = avs_read_in || avs_write_in;
    status = 32'h0000_0000;
    status[stp_pkg::ST_P1_LSB +: 2] = port_class(p1_ff);
    status[stp_pkg::ST_P2_LSB +: 2] = port_class(p2_ff);
    status[stp_pkg::ST_IGMP_LSB +: 8] = igmp_cnt_ff;
    status[stp_pkg::ST_MLD_LSB +: 8] = mld_cnt_ff;
    nxt_bus = bus_ff;
    nxt_wait = 1'b1;
    nxt_rdata = rdata_ff;
    nxt_glob = glob_ff;
    nxt_p1 = p1_ff;
    nxt_p2 = p2_ff;
    case (bus_ff)
      stp_pkg::STP_BUS_IDLE: begin
        if (req) begin
          // One wait cycle keeps read data off a combinational path
          nxt_bus = stp_pkg::STP_BUS_ACK;
          nxt_wait = 1'b0;
          case (avs_address_in)
            stp_pkg::REG_GLOBAL: nxt_rdata = {16'h0000, glob_ff};
            stp_pkg::REG_PORT_ONE: nxt_rdata = {16'h0000, p1_ff};
            stp_pkg::REG_PORT_TWO: nxt_rdata = {16'h0000, p2_ff};
            stp_pkg::REG_STATUS: nxt_rdata = status;
            default: nxt_rdata = 32'h0000_0000;
          endcase
        end
      end
      stp_pkg::STP_BUS_ACK: begin
        nxt_bus = stp_pkg::STP_BUS_IDLE;
        if (avs_write_in) begin
          case (avs_address_in)
            stp_pkg::REG_GLOBAL:
              nxt_glob = merge16(glob_ff, avs_writedata_in, avs_byteenable_in);
            stp_pkg::REG_PORT_ONE:
              nxt_p1 = merge16(p1_ff, avs_writedata_in, avs_byteenable_in);
            stp_pkg::REG_PORT_TWO:
              nxt_p2 = merge16(p2_ff, avs_writedata_in, avs_byteenable_in);
            default: nxt_glob = glob_ff;
          endcase
        end
      end
      default: nxt_bus = stp_pkg::STP_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      bus_ff <= stp_pkg::STP_BUS_IDLE;
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
      glob_ff <= stp_pkg::GLOBAL_RST;
      p1_ff <= stp_pkg::PORT_RST;
      p2_ff <= stp_pkg::PORT_RST;
    end else begin
      bus_ff <= nxt_bus;
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
      glob_ff <= nxt_glob;
      p1_ff <= nxt_p1;
      p2_ff <= nxt_p2;
    end
  end

  assign avs_readdata_out = rdata_ff;
  assign avs_waitrequest_out = wait_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Snoop classifier
  stp_hdr_if hif ();
  assign hif.length_type = length_type_in;
  assign hif.snap_ok = snap_ok_in;
  assign hif.snap_type = snap_type_in;
  assign hif.ip_ver = ip_ver_in;
  assign hif.ip_proto = ip_proto_in;
  assign hif.ip6_dst_top = ip6_dst_top_in;
  assign hif.hop_limit = hop_limit_in;
  assign hif.next_hdr = next_hdr_in;
  assign hif.hbh_next_hdr = hbh_next_hdr_in;
  assign hif.mld_en = glob_ff[stp_pkg::BIT_MLD_EN];
  assign hif.mld_opt = glob_ff[stp_pkg::BIT_MLD_OPT];

  stp_snoop_cls u_cls (
    .hif(hif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Forwarding decision
  logic val_ff, nxt_val;
  logic [2:0] dest_ff, nxt_dest;
  logic learn_ff, nxt_learn;
  logic trap_ff, nxt_trap;
  logic [1:0] tx_en;
  logic [1:0] rx_en;
  logic [1:0] lrn_dis;
  logic src_host;
  logic src_rx;
  logic src_lrn_dis;
  logic trap;
  logic [2:0] base;
  logic [2:0] gated;

  assign tx_en = {p2_ff[stp_pkg::BIT_TX_EN], p1_ff[stp_pkg::BIT_TX_EN]};
  assign rx_en = {p2_ff[stp_pkg::BIT_RX_EN], p1_ff[stp_pkg::BIT_RX_EN]};
  assign lrn_dis = {p2_ff[stp_pkg::BIT_LEARN_DIS], p1_ff[stp_pkg::BIT_LEARN_DIS]};

  // Egress to a closed port is only allowed for frames from the processor
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_egress
      assign gated[gp] = base[gp] && (src_port_in != 2'(gp)) &&
        (tx_en[gp] || src_host);
    end
  endgenerate
  assign gated[2] = base[2] && !src_host;

  always_comb begin
    src_host = (src_port_in == stp_pkg::PORT_HOST);
    src_rx = src_host || ((src_port_in == stp_pkg::PORT_ONE) ? rx_en[0] : rx_en[1]);
    src_lrn_dis = !src_host &&
      ((src_port_in == stp_pkg::PORT_ONE) ? lrn_dis[0] : lrn_dis[1]);
    trap = !src_host && (hif.igmp_hit || hif.mld_hit);
    // Static entry overrides the learned or flooded set
    base = static_hit_in ? static_ports_in : lookup_ports_in;
    nxt_val = hdr_valid_in;
    nxt_trap = 1'b0;
    nxt_learn = 1'b0;
    nxt_dest = dest_ff;
    if (hdr_valid_in) begin
      nxt_learn = !src_lrn_dis;
      if (!src_rx) begin
        // Closed port still delivers override entries to the host
        nxt_dest = (static_hit_in && static_override_in && static_ports_in[2]) ?
          stp_pkg::MASK_HOST : stp_pkg::MASK_NONE;
      end else if (trap) begin
        nxt_dest = stp_pkg::MASK_HOST;
        nxt_trap = 1'b1;
      end else begin
        nxt_dest = gated;
      end
    end
  end

  always_comb begin
    nxt_igmp_cnt = igmp_cnt_ff;
    nxt_mld_cnt = mld_cnt_ff;
    if (hdr_valid_in && src_rx && trap) begin
      if (hif.igmp_hit) begin
        nxt_igmp_cnt = igmp_cnt_ff + 8'h01;
      end else begin
        nxt_mld_cnt = mld_cnt_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      val_ff <= 1'b0;
      dest_ff <= 3'h0;
      learn_ff <= 1'b0;
      trap_ff <= 1'b0;
      igmp_cnt_ff <= 8'h00;
      mld_cnt_ff <= 8'h00;
    end else begin
      val_ff <= nxt_val;
      dest_ff <= nxt_dest;
      learn_ff <= nxt_learn;
      trap_ff <= nxt_trap;
      igmp_cnt_ff <= nxt_igmp_cnt;
      mld_cnt_ff <= nxt_mld_cnt;
    end
  end

  assign dec_valid_out = val_ff;
  assign dest_ports_out = dest_ff;
  assign learn_out = learn_ff;
  assign trap_out = trap_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  chk_trap_host_only: assert property (
    val_ff && trap_ff |-> dest_ff == 3'h4)
    else $error("trapped frame not sent to host alone");
  chk_igmp_classify: assert property (
    hdr_valid_in && !src_host && src_rx && length_type_in == 16'h0800 &&
    ip_ver_in == 4'h4 && ip_proto_in == 8'h02 |=> trap_ff && dest_ff == 3'h4)
    else $error("IGMP frame not trapped");
  chk_closed_drop: assert property (
    hdr_valid_in && !src_rx && !static_override_in |=> dest_ff == 3'h0 && !trap_ff)
    else $error("closed port passed a frame");
  chk_learn_follow: assert property (
    hdr_valid_in && src_port_in == 2'h0 |=> learn_ff == !$past(p1_ff[0]))
    else $error("learning does not follow port one control");
  chk_tx_gate: assert property (
    hdr_valid_in && src_port_in == 2'h0 && !p2_ff[2] |=> !dest_ff[1])
    else $error("network frame reached closed port two");
  chk_fwd_normal: assert property (
    hdr_valid_in && src_port_in == 2'h0 && p1_ff[2:0] == 3'h6 && p2_ff[2:0] == 3'h6 &&
    !trap && !static_hit_in && lookup_ports_in[1] |=> dest_ff[1] && learn_ff)
    else $error("forwarding state did not forward");
  chk_mld_off: assert property (
    hdr_valid_in && !glob_ff[13] && !hif.igmp_hit |=> !trap_ff)
    else $error("MLD trap while snooping disabled");
  chk_static_mcast: assert property (
    hdr_valid_in && src_host && static_hit_in |=> dest_ff == {1'b0, $past(static_ports_in[1:0])})
    else $error("static entry ports not honoured");
  chk_mld_opt: assert property (
    hdr_valid_in && !src_host && src_rx && glob_ff[13:12] == 2'h3 &&
    length_type_in == 16'h86DD && ip6_dst_top_in == 8'hFF && hop_limit_in == 8'h01 &&
    next_hdr_in == 8'h2C |=> trap_ff)
    else $error("extension header MLD frame not trapped");
  chk_bus_answer: assert property (
    bus_ff == stp_pkg::STP_BUS_IDLE && (avs_read_in || avs_write_in) |=> !wait_ff ##1 wait_ff)
    else $error("bus answer not one cycle after request");

  cov_trap_igmp: cover property (val_ff && trap_ff && $past(hif.igmp_hit));
  cov_override_closed: cover property (hdr_valid_in && !src_rx && static_override_in);
  cov_learn_state: cover property (hdr_valid_in && port_class(p1_ff) == stp_pkg::STP_LEARN);
  cov_reg_write: cover property (bus_ff == stp_pkg::STP_BUS_ACK && avs_write_in);
endmodule

// ### stp_pkg.sv
// Constants and types for the port state and snoop trap block
package stp_pkg;
  // Register word indices (byte address is four times the index)
  localparam logic [2:0] REG_GLOBAL = 3'h0;
  localparam logic [2:0] REG_PORT_ONE = 3'h1;
  localparam logic [2:0] REG_PORT_TWO = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  // Field positions
  localparam int BIT_MLD_EN = 13;
  localparam int BIT_MLD_OPT = 12;
  localparam int BIT_TX_EN = 2;
  localparam int BIT_RX_EN = 1;
  localparam int BIT_LEARN_DIS = 0;
  localparam int ST_P1_LSB = 0;
  localparam int ST_P2_LSB = 2;
  localparam int ST_IGMP_LSB = 8;
  localparam int ST_MLD_LSB = 16;
  // Reset values
  localparam logic [15:0] GLOBAL_RST = 16'h0000;
  localparam logic [15:0] PORT_RST = 16'h0006;
  // Port numbering and masks
  localparam logic [1:0] PORT_ONE = 2'h0;
  localparam logic [1:0] PORT_TWO = 2'h1;
  localparam logic [1:0] PORT_HOST = 2'h2;
  localparam logic [2:0] MASK_HOST = 3'h4;
  localparam logic [2:0] MASK_NONE = 3'h0;
  // Frame field codes
  localparam logic [15:0] ETH_IPV4 = 16'h0800;
  localparam logic [15:0] ETH_IPV6 = 16'h86DD;
  localparam logic [15:0] ETH_MAX_LEN = 16'h05DC;
  localparam logic [3:0] IP_VER4 = 4'h4;
  localparam logic [7:0] PROTO_IGMP = 8'h02;
  localparam logic [7:0] IP6_MCAST = 8'hFF;
  localparam logic [7:0] HOP_ONE = 8'h01;
  localparam logic [7:0] NH_HBH = 8'h00;
  localparam logic [7:0] NH_ICMP = 8'h01;
  localparam logic [7:0] NH_ICMP6 = 8'h3A;
  localparam logic [7:0] NH_ROUTE = 8'h2B;
  localparam logic [7:0] NH_FRAG = 8'h2C;
  localparam logic [7:0] NH_ESP = 8'h32;
  localparam logic [7:0] NH_AUTH = 8'h33;
  localparam logic [7:0] NH_DEST = 8'h3C;
  // Decoded spanning tree class of a port
  typedef enum logic [1:0] {
    STP_CLOSED = 2'b00,
    STP_LEARN = 2'b01,
    STP_FORWARD = 2'b10,
    STP_OTHER = 2'b11
  } stp_class_t;
  typedef enum logic [0:0] {
    STP_BUS_IDLE = 1'b0,
    STP_BUS_ACK = 1'b1
  } stp_bus_t;
endpackage

// ### stp_hdr_if.sv
// Header fields and snoop results between the top and the classifier
`timescale 1ns/10ps
interface stp_hdr_if;
  logic [15:0] length_type;
  logic snap_ok;
  logic [15:0] snap_type;
  logic [3:0] ip_ver;
  logic [7:0] ip_proto;
  logic [7:0] ip6_dst_top;
  logic [7:0] hop_limit;
  logic [7:0] next_hdr;
  logic [7:0] hbh_next_hdr;
  logic mld_en;
  logic mld_opt;
  logic igmp_hit;
  logic mld_hit;
  modport cls (input length_type, snap_ok, snap_type, ip_ver, ip_proto, ip6_dst_top,
    hop_limit, next_hdr, hbh_next_hdr, mld_en, mld_opt, output igmp_hit, mld_hit);
  modport top (output length_type, snap_ok, snap_type, ip_ver, ip_proto, ip6_dst_top,
    hop_limit, next_hdr, hbh_next_hdr, mld_en, mld_opt, input igmp_hit, mld_hit);
endinterface

// ### stp_snoop_cls.sv
// Classifier that spots IGMP and IPv6 MLD control frames
`timescale 1ns/10ps
module stp_snoop_cls (
  stp_hdr_if.cls hif
);
  function automatic logic is_mld_nh(input logic [7:0] nh);
    is_mld_nh = (nh == stp_pkg::NH_ICMP) || (nh == stp_pkg::NH_ICMP6);
  endfunction

  function automatic logic is_ext_nh(input logic [7:0] nh);
    is_ext_nh = (nh == stp_pkg::NH_ROUTE) || (nh == stp_pkg::NH_FRAG) ||
      (nh == stp_pkg::NH_ESP) || (nh == stp_pkg::NH_AUTH) || (nh == stp_pkg::NH_DEST);
  endfunction

  logic is_ip4;
  logic is_ip6;
  logic hbh;
  logic nh_match;

  always_comb begin
    // Ethernet-type IPv4 or 802.3 SNAP carrying IPv4
    is_ip4 = (hif.length_type == stp_pkg::ETH_IPV4) ||
      ((hif.length_type <= stp_pkg::ETH_MAX_LEN) && hif.snap_ok &&
      (hif.snap_type == stp_pkg::ETH_IPV4));
    hif.igmp_hit = is_ip4 && (hif.ip_ver == stp_pkg::IP_VER4) &&
      (hif.ip_proto == stp_pkg::PROTO_IGMP);
    is_ip6 = (hif.length_type == stp_pkg::ETH_IPV6) &&
      (hif.ip6_dst_top == stp_pkg::IP6_MCAST) && (hif.hop_limit == stp_pkg::HOP_ONE);
    hbh = (hif.next_hdr == stp_pkg::NH_HBH);
    nh_match = is_mld_nh(hif.next_hdr) || (hbh && is_mld_nh(hif.hbh_next_hdr));
    if (hif.mld_opt) begin
      // Extension headers only trap when the option is on
      nh_match = nh_match || is_ext_nh(hif.next_hdr) || (hbh && is_ext_nh(hif.hbh_next_hdr));
    end
    // Enable gates every MLD hit; option alone never traps
    hif.mld_hit = hif.mld_en && is_ip6 && nh_match;
  end
endmodule

// ### stp_host_model.sv
// Behavioural management processor sitting on the host port
`timescale 1ns/10ps
module stp_host_model (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic hdr_valid_in,
  input wire logic [1:0] src_port_in,
  input wire logic [1:0] closed_in,
  input wire logic dec_valid_in,
  input wire logic [2:0] dest_ports_in,
  output logic [7:0] kept_out,
  output logic [7:0] dropped_out
);
  logic [1:0] src_ff;
  logic from_closed;
  ////////////////////////////////////////////////////////////////////////////////
  // Source is latched with the header, since the decision lands a cycle later
  assign from_closed = (src_ff != stp_pkg::PORT_HOST) && closed_in[src_ff[0]];
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      src_ff <= 2'h0;
      kept_out <= 8'h00;
      dropped_out <= 8'h00;
    end else begin
      if (hdr_valid_in) begin
        src_ff <= src_port_in;
      end
      if (dec_valid_in && dest_ports_in[2]) begin
        // Override frames from a closed port are thrown away, never used
        if (from_closed) begin
          dropped_out <= dropped_out + 8'h01;
        end else begin
          kept_out <= kept_out + 8'h01;
        end
      end
    end
  end
endmodule

// ### stp_port_state_and_snoop_trap_bench.sv
// Self-checking bench for the port state and snoop trap block
`timescale 1ns/10ps
module stp_port_state_and_snoop_trap_bench;
  typedef struct packed {
    logic [1:0] src; logic [15:0] lt; logic snap; logic [15:0] st; logic [3:0] ver;
    logic [7:0] proto; logic [7:0] dtop; logic [7:0] hop; logic [7:0] nh; logic [7:0] hbh;
    logic sh; logic so; logic [2:0] sp; logic [2:0] lp;
  } stp_stim_t;
  logic clock_in, rst_in, avs_read, avs_write, avs_waitrequest_out, hdr_valid;
  logic [2:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata_out, q;
  logic dec_valid_out, learn_out, trap_out;
  logic [2:0] dest_ports_out;
  logic [1:0] closed;
  logic [7:0] kept, dropped, n_mld;
  logic [26:0] mld_rows [15];
  stp_stim_t h, hq;
  int err_count, compares;
  ////////////////////////////////////////////////////////////////////////////////
  stp_port_state_and_snoop_trap stp_port_state_and_snoop_trap_inst (
    .clock_in(clock_in), .rst_in(rst_in), .avs_address_in(avs_address),
    .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
    .avs_byteenable_in(4'h3), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .hdr_valid_in(hdr_valid),
    .src_port_in(hq.src), .length_type_in(hq.lt), .snap_ok_in(hq.snap), .snap_type_in(hq.st),
    .ip_ver_in(hq.ver), .ip_proto_in(hq.proto), .ip6_dst_top_in(hq.dtop),
    .hop_limit_in(hq.hop), .next_hdr_in(hq.nh), .hbh_next_hdr_in(hq.hbh),
    .static_hit_in(hq.sh), .static_override_in(hq.so), .static_ports_in(hq.sp),
    .lookup_ports_in(hq.lp), .dec_valid_out(dec_valid_out), .dest_ports_out(dest_ports_out),
    .learn_out(learn_out), .trap_out(trap_out));
  stp_host_model stp_host_model_inst (
    .clock_in(clock_in), .rst_in(rst_in), .hdr_valid_in(hdr_valid), .src_port_in(hq.src),
    .closed_in(closed), .dec_valid_in(dec_valid_out), .dest_ports_in(dest_ports_out),
    .kept_out(kept), .dropped_out(dropped));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("Counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Request held until waitrequest is sampled low; wait bounded by the watchdog
  task automatic acc(input logic w, input logic [2:0] a, input logic [31:0] d);
    @(posedge clock_in);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clock_in);
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [2:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0000_0000);
    chk(n, e, q);
  endtask
  function automatic stp_stim_t mk(input logic [1:0] s, input logic [2:0] lp);
    return '{s, 16'h0800, 1'h0, 16'h0000, 4'h4, 8'h06, 8'h00, 8'h40, 8'h06, 8'h06,
      1'h0, 1'h0, 3'h0, lp};
  endfunction
  // One header pulse; decision looked at once its edge has landed
  task automatic send(input logic [2:0] ed, input logic el, input logic et);
    @(posedge clock_in);
    hq <= h;
    hdr_valid <= 1'b1;
    @(posedge clock_in);
    hdr_valid <= 1'b0;
    #1;
    chk("dec_valid", 32'h1, dec_valid_out);
    chk("dest", ed, dest_ports_out);
    chk("learn", el, learn_out);
    chk("trap", et, trap_out);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = !clock_in;
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    err_count++;
    tally_and_finish();
  end
  initial begin
    rst_in = 1'b1;
    {avs_read, avs_write, hdr_valid, avs_address, avs_writedata} = '0;
    closed = 2'h0;
    n_mld = 8'h00;
    h = mk(2'h0, 3'h0);
    hq = h;
    mld_rows = '{{2'h2, 8'h01, 8'h00, 8'h01, 1'h1}, {2'h2, 8'h3A, 8'h00, 8'h01, 1'h1},
      {2'h2, 8'h00, 8'h3A, 8'h01, 1'h1}, {2'h2, 8'h00, 8'h01, 8'h01, 1'h1},
      {2'h2, 8'h2B, 8'h00, 8'h01, 1'h0}, {2'h2, 8'h3A, 8'h00, 8'h02, 1'h0},
      {2'h3, 8'h2B, 8'h00, 8'h01, 1'h1}, {2'h3, 8'h2C, 8'h00, 8'h01, 1'h1},
      {2'h3, 8'h32, 8'h00, 8'h01, 1'h1}, {2'h3, 8'h33, 8'h00, 8'h01, 1'h1},
      {2'h3, 8'h3C, 8'h00, 8'h01, 1'h1}, {2'h3, 8'h00, 8'h2C, 8'h01, 1'h1},
      {2'h3, 8'h06, 8'h00, 8'h01, 1'h0}, {2'h1, 8'h3A, 8'h00, 8'h01, 1'h0},
      {2'h1, 8'h2B, 8'h00, 8'h01, 1'h0}};
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    // Reset values, read back and unmapped places
    rdc("global", 3'h0, 32'h0000_0000);
    rdc("port_one", 3'h1, 32'h0000_0006);
    rdc("port_two", 3'h2, 32'h0000_0006);
    rdc("status", 3'h3, 32'h0000_000A);
    acc(1'b1, 3'h6, 32'h0000_FFFF);
    rdc("unmapped", 3'h6, 32'h0000_0000);
    $display("TEST registers done");
    // Forwarding: normal traffic, ingress port dropped from the mask
    h = mk(2'h0, 3'h7);
    send(3'h6, 1'h1, 1'h0);
    // Closed port one: only processor traffic, no learning, override entry only
    acc(1'b1, 3'h1, 32'h0000_0001);
    closed = 2'h1;
    rdc("status", 3'h3, 32'h0000_0008);
    send(3'h0, 1'h0, 1'h0);
    h.sh = 1'h1;
    h.so = 1'h1;
    h.sp = 3'h4;
    send(3'h4, 1'h0, 1'h0);
    h = mk(2'h2, 3'h1);
    send(3'h1, 1'h1, 1'h0);
    // Learning state: only processor traffic but addresses learned
    acc(1'b1, 3'h1, 32'h0000_0000);
    closed = 2'h0;
    rdc("status", 3'h3, 32'h0000_0009);
    h = mk(2'h0, 3'h7);
    h.sh = 1'h1;
    h.so = 1'h1;
    h.sp = 3'h4;
    send(3'h4, 1'h1, 1'h0);
    // Closed port two refuses traffic from the forwarding port
    acc(1'b1, 3'h1, 32'h0000_0006);
    acc(1'b1, 3'h2, 32'h0000_0001);
    h = mk(2'h0, 3'h6);
    send(3'h4, 1'h1, 1'h0);
    // Tx-only code on port two decodes as the catch-all class
    acc(1'b1, 3'h2, 32'h0000_0004);
    rdc("status", 3'h3, 32'h0000_000E);
    acc(1'b1, 3'h2, 32'h0000_0006);
    $display("TEST port states done");
    // IGMP over Ethernet type and over SNAP; wrong version not trapped
    h = mk(2'h0, 3'h7);
    h.proto = stp_pkg::PROTO_IGMP;
    send(stp_pkg::MASK_HOST, 1'h1, 1'h1);
    h.lt = 16'h0040;
    h.snap = 1'h1;
    h.st = stp_pkg::ETH_IPV4;
    send(stp_pkg::MASK_HOST, 1'h1, 1'h1);
    h.ver = 4'h6;
    send(3'h6, 1'h1, 1'h0);
    // Static multicast entry trims the flood
    h = mk(2'h1, 3'h7);
    h.sh = 1'h1;
    h.sp = 3'h3;
    send(3'h1, 1'h1, 1'h0);
    // Processor-sourced group frame: static mask honoured, never back to host
    h = mk(2'h2, 3'h7);
    h.sh = 1'h1;
    h.sp = 3'h6;
    send(3'h2, 1'h1, 1'h0);
    $display("TEST igmp and static done");
    // MLD table: enable, option and their absence
    for (int i = 0; i < 15; i++) begin
      acc(1'b1, 3'h0, {16'h0000, 2'h0, mld_rows[i][26:25], 12'h000});
      h = mk(2'h0, 3'h7);
      h.lt = stp_pkg::ETH_IPV6;
      h.dtop = stp_pkg::IP6_MCAST;
      {h.nh, h.hbh, h.hop} = mld_rows[i][24:1];
      n_mld = n_mld + {7'h00, mld_rows[i][0]};
      send(mld_rows[i][0] ? 3'h4 : 3'h6, 1'h1, mld_rows[i][0]);
    end
    rdc("global", 3'h0, 32'h0000_1000);
    // Trap counters, and a write to the read-only word is ignored
    acc(1'b1, 3'h3, 32'h0000_0000);
    rdc("status", 3'h3, {8'h00, n_mld, 8'h02, 8'h0A});
    chk("host_drops", 32'h1, dropped);
    chk("host_kept", 32'h15, kept);
    $display("TEST mld done");
    tally_and_finish();
  end
endmodule
